// ### logic/zone3_compat_checker.sv
/*
 * Walks the rear module's multi-record list byte by byte and reports
 * whether any record matches the carrier's own compatibility record.
 * Assumes the FRU store answers each read with fru_valid one or more
 * cycles after fru_rd, on this clock, and answers every read.
 */
`timescale 1ns/1ps
module zone3_compat_checker
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [15:0] list_base,
    output logic fru_rd_q,
    output logic [15:0] fru_addr_q,
    input wire logic fru_valid,
    input wire logic [7:0] fru_data,
    output logic busy_q,
    output logic done_q,
    output logic compatible_q,
    output logic list_error_q
);
    import zone3_pkg::*;

    default clocking walk_cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ========================================================
    // state
    // ========================================================
    walk_state_type state_q;
    logic [15:0] base_q;
    logic [8:0] off_q;
    logic pending_q;
    logic type_ok_q;
    logic ver_ok_q;
    logic last_q;
    logic [7:0] len_q;
    logic match_q;
    logic found_q;
    logic [7:0] ref_byte;
    logic [7:0] hdr_sum;
    logic [7:0] body_sum;
    logic take;
    logic in_hdr;
    logic in_body;
    logic hdr_end;
    logic hdr_bad;
    logic rec_done;
    logic rec_ok;
    logic byte_match;
    logic [15:0] next_base;

    assign take = pending_q && fru_valid && (state_q != ST_IDLE);
    assign in_hdr = take && (state_q == ST_HDR);
    assign in_body = take && (state_q == ST_BODY);
    assign hdr_end = in_hdr && (off_q == OFF_HDR_SUM);
    // header bytes plus this checksum byte must sum to zero
    assign hdr_bad = hdr_end && (byte_sum(hdr_sum, fru_data) != 8'h00);
    // body runs offsets 5 to 4+len
    assign rec_done = (hdr_end && !hdr_bad && len_q == 8'h00)
        || (in_body && off_q == 9'(OFF_HDR_SUM + 9'(len_q)));
    // compare from byte 8 on; ref holds 30h there, equal from 9
    assign byte_match = (off_q < OFF_REC_ID) || (fru_data == ref_byte);
    // all must hold for a match
    assign rec_ok = type_ok_q && ver_ok_q && (len_q == REF_LEN)
        && match_q && byte_match
        && (byte_sum(body_sum, in_body ? fru_data : 8'h00) == 8'h00);
    // next header follows the five header bytes and the body
    assign next_base = 16'(base_q + 16'(OFF_BODY) + 16'(len_q));

    zone3_ref_rom u_ref
    (
        .clock(clock),
        .rst_n(rst_n),
        .addr(off_q),
        .data_q(ref_byte)
    );

    zone3_sum_acc u_hdr_sum
    (
        .clock(clock),
        .rst_n(rst_n),
        .clear(start && state_q == ST_IDLE || rec_done),
        .add(in_hdr),
        .data(fru_data),
        .sum_q(hdr_sum)
    );

    zone3_sum_acc u_body_sum
    (
        .clock(clock),
        .rst_n(rst_n),
        .clear(start && state_q == ST_IDLE || rec_done),
        .add(take && (off_q == OFF_BODY_SUM || off_q >= OFF_BODY)),
        .data(fru_data),
        .sum_q(body_sum)
    );

    // ========================================================
    // walk sequencing
    // ========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            base_q <= 16'h0000;
            off_q <= 9'h000;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (start)
                    begin
                        state_q <= ST_HDR;
                        base_q <= list_base;
                        off_q <= 9'h000;
                    end
                ST_HDR, ST_BODY:
                    if (hdr_bad)
                        state_q <= ST_DONE;
                    else if (rec_done && last_q)
                        state_q <= ST_DONE;
                    else if (rec_done)
                    begin
                        state_q <= ST_HDR;
                        base_q <= next_base;
                        off_q <= 9'h000;
                    end
                    else if (take)
                    begin
                        off_q <= 9'(off_q + 9'h001);
                        if (hdr_end)
                            state_q <= ST_BODY;
                    end
                ST_DONE:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // one read outstanding at a time keeps rom and store aligned
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_q <= 1'b0;
            fru_rd_q <= 1'b0;
            fru_addr_q <= 16'h0000;
        end
        else
        begin
            fru_rd_q <= 1'b0;
            if (take)
                pending_q <= 1'b0;
            else if (!pending_q && (state_q == ST_HDR || state_q == ST_BODY))
            begin
                pending_q <= 1'b1;
                fru_rd_q <= 1'b1;
                fru_addr_q <= 16'(base_q + 16'(off_q));
            end
        end
    end

    // ========================================================
    // field capture
    // ========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            type_ok_q <= 1'b0;
            ver_ok_q <= 1'b0;
            last_q <= 1'b0;
            len_q <= 8'h00;
            match_q <= 1'b0;
        end
        else if (in_hdr && off_q == OFF_TYPE)
        begin
            type_ok_q <= (fru_data == REC_TYPE_OEM);
            match_q <= 1'b1;
        end
        else if (in_hdr && off_q == OFF_FLAGS)
        begin
            last_q <= fru_data[END_BIT];
            ver_ok_q <= (fru_data[VER_LSB+:4] == HDR_VERSION);
        end
        else if (in_hdr && off_q == OFF_LEN)
            len_q <= fru_data;
        else if (in_body && !byte_match)
            match_q <= 1'b0;
    end

    // ========================================================
    // result
    // ========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            found_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            compatible_q <= 1'b0;
            list_error_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (state_q == ST_IDLE && start)
            begin
                found_q <= 1'b0;
                busy_q <= 1'b1;
                list_error_q <= 1'b0;
            end
            else if (rec_done && rec_ok)
                found_q <= 1'b1;
            if (hdr_bad)
                list_error_q <= 1'b1;
            if (state_q == ST_DONE)
            begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                compatible_q <= found_q;
            end
        end
    end

    // ========================================================
    // checks
    // ========================================================
    type_gate_a: assert property (in_hdr && off_q == OFF_TYPE
        |=> type_ok_q == ($past(fru_data) == REC_TYPE_OEM))
        else $error("type byte not captured");
    last_stop_a: assert property (rec_done && last_q && !hdr_bad
        |=> state_q == ST_DONE ##1 done_q)
        else $error("walk did not stop after last record");
    last_cap_a: assert property (in_hdr && off_q == OFF_FLAGS
        |=> last_q == $past(fru_data[END_BIT]))
        else $error("end of list flag not captured");
    hdr_version_a: assert property (in_hdr && off_q == OFF_FLAGS
        |=> ver_ok_q == ($past(fru_data[VER_LSB+:4]) == HDR_VERSION))
        else $error("header version not captured");
    body_sum_a: assert property (in_hdr && off_q == OFF_BODY_SUM
        |=> body_sum == $past(fru_data))
        else $error("body sum not seeded by checksum byte");
    hdr_sum_a: assert property (hdr_bad
        |=> state_q == ST_DONE ##1 (done_q && list_error_q))
        else $error("bad header checksum not ending walk");
    error_clear_a: assert property (state_q == ST_IDLE && start
        |=> !list_error_q)
        else $error("header error carried into new walk");
    len_equal_a: assert property ($rose(found_q)
        |-> $past(rec_done) && $past(len_q) == REF_LEN)
        else $error("match accepted with unequal length");
    mismatch_a: assert property (in_body && off_q >= OFF_REC_ID
        && fru_data != ref_byte |=> !match_q)
        else $error("differing byte left record matching");
    found_set_a: assert property (rec_done && rec_ok
        |=> found_q [*2])
        else $error("matching record not remembered");
    result_out_a: assert property (done_q
        |-> compatible_q == $past(found_q) && !busy_q)
        else $error("result differs from match history");
    result_hold_a: assert property (!done_q
        |-> $stable(compatible_q))
        else $error("result changed outside done");
    empty_list_a: assert property (state_q == ST_IDLE && start
        |=> !found_q)
        else $error("stale match carried into new walk");
    sum_clear_a: assert property (rec_done
        |=> hdr_sum == 8'h00 && body_sum == 8'h00)
        else $error("checksums not restarted per record");
    hdr_acc_a: assert property (in_hdr && !hdr_end
        |=> hdr_sum == $past(byte_sum(hdr_sum, fru_data)))
        else $error("header sum step wrong");
    next_hdr_a: assert property (rec_done && !last_q && !hdr_bad
        |=> state_q == ST_HDR && off_q == 9'h000
            && base_q == $past(next_base))
        else $error("next header address wrong");
    busy_start_a: assert property (state_q == ST_IDLE && start
        |=> busy_q && state_q == ST_HDR && base_q == $past(list_base))
        else $error("walk did not start from the given base");
    rd_addr_a: assert property (fru_rd_q
        |-> pending_q && fru_addr_q == 16'(base_q + 16'(off_q)))
        else $error("read address off the walk position");
    rd_pulse_a: assert property (fru_rd_q |=> !fru_rd_q)
        else $error("read strobe longer than one cycle");
    done_pulse_a: assert property (done_q |=> !done_q)
        else $error("done longer than one cycle");
    idle_quiet_a: assert property (state_q == ST_IDLE
        |-> !pending_q && !fru_rd_q && !busy_q)
        else $error("activity while idle");
    done_state_a: assert property (state_q == ST_DONE
        |=> done_q && !busy_q && state_q == ST_IDLE)
        else $error("done state did not finish walk");
    byte_step_a: assert property (take && !rec_done && !hdr_bad
        |=> off_q == $past(off_q) + 9'h001)
        else $error("offset did not advance on data");
    len_cap_a: assert property (in_hdr && off_q == OFF_LEN
        |=> len_q == $past(fru_data))
        else $error("length byte not captured");
    body_start_a: assert property (hdr_end && !hdr_bad
        && len_q != 8'h00 |=> state_q == ST_BODY && off_q == OFF_BODY)
        else $error("body did not follow header");
endmodule // zone3_compat_checker

// ### logic/zone3_pkg.sv
/*
 * Constants shared by the rear module compatibility checker: record
 * layout, field positions, fixed codes and the walk's state encoding.
 * Assumes a byte-wide FRU store addressed with 16 bits.
 */
// Operation
// - Only records whose first byte is the OEM type code are candidates.
// - Bit 7 of header byte 1 marks the last record; bits 6:4 are reserved.
// - The low nibble of header byte 1 is the header version and must be 2.
// - Byte 3 is a zero checksum over the body; a failing body is rejected.
// - Byte 4 is a zero checksum over the header; a failing header is bad.
// - Byte 8 holds the fixed industry record identifier 30h.
// - Byte 9 holds the body format version, which must be 1.
// - Byte 10 holds the interface identifier type, 3 meaning OEM owned.
// - Bytes 11 to 13 hold the owner's enterprise number, low byte first.
// - From byte 14 a 32-bit interface designator follows, low byte first.
// - Records match only with equal lengths and equal bytes 9 to the end.
// - The module is compatible when any record matches, else incompatible.
// - A list with no compatibility record yields incompatible.
package zone3_pkg;
    localparam logic [7:0] REC_TYPE_OEM = 8'hc0;
    localparam logic [3:0] HDR_VERSION = 4'h2;
    localparam logic [7:0] PICMG_REC_ID = 8'h30;
    localparam logic [7:0] BODY_VERSION = 8'h01;
    localparam logic [7:0] IFACE_TYPE_OEM = 8'h03;
    localparam int END_BIT = 7;
    localparam int VER_LSB = 0;
    localparam logic [8:0] OFF_TYPE = 9'h000;
    localparam logic [8:0] OFF_FLAGS = 9'h001;
    localparam logic [8:0] OFF_LEN = 9'h002;
    localparam logic [8:0] OFF_BODY_SUM = 9'h003;
    localparam logic [8:0] OFF_HDR_SUM = 9'h004;
    localparam logic [8:0] OFF_BODY = 9'h005;
    localparam logic [8:0] OFF_REC_ID = 9'h008;
    localparam logic [8:0] OFF_MATCH = 9'h009;
    localparam logic [7:0] REF_LEN = 8'h0d;
    localparam int REF_BYTES = 18;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_BODY = 2'b10,
        ST_DONE = 2'b11
    } walk_state_type;

    function automatic logic [7:0] byte_sum(input logic [7:0] a,
                                            input logic [7:0] b);
        byte_sum = 8'(a + b);
    endfunction
endpackage

// ### logic/zone3_ref_rom.sv
/*
 * The carrier's own compatibility record, read one byte per cycle.
 * Assumes the reader holds the address until it consumes the data.
 */
`timescale 1ns/1ps
module zone3_ref_rom
#(
    parameter logic [23:0] MAKER_ID = 24'h000002,   // arbitrary value
    parameter logic [23:0] OWNER_ID = 24'h000001,   // arbitrary value
    parameter logic [31:0] DESIGNATOR = 32'h00000001 // arbitrary value
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [8:0] addr,
    output logic [7:0] data_q
);
    import zone3_pkg::*;

    logic [7:0] rom [0:REF_BYTES-1];

    // checksum bytes sit below the compared range, so they stay zero
    assign rom[0] = REC_TYPE_OEM;
    assign rom[1] = {1'b1, 3'h0, HDR_VERSION};
    assign rom[2] = REF_LEN;
    assign rom[3] = 8'h00;
    assign rom[4] = 8'h00;
    assign rom[5] = MAKER_ID[7:0];
    assign rom[6] = MAKER_ID[15:8];
    assign rom[7] = MAKER_ID[23:16];
    assign rom[8] = PICMG_REC_ID;
    assign rom[9] = BODY_VERSION;
    assign rom[10] = IFACE_TYPE_OEM;
    assign rom[11] = OWNER_ID[7:0];
    assign rom[12] = OWNER_ID[15:8];
    assign rom[13] = OWNER_ID[23:16];
    assign rom[14] = DESIGNATOR[7:0];
    assign rom[15] = DESIGNATOR[15:8];
    assign rom[16] = DESIGNATOR[23:16];
    assign rom[17] = DESIGNATOR[31:24];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            data_q <= 8'h00;
        else if (addr < 9'(REF_BYTES))
            data_q <= rom[addr[4:0]];
        else
            data_q <= 8'h00;
    end
endmodule // zone3_ref_rom

// ### logic/zone3_sum_acc.sv
/*
 * Byte accumulator for a zero checksum.
 * Assumes clear and add never both matter in one cycle; clear wins.
 */
`timescale 1ns/1ps
module zone3_sum_acc
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [7:0] sum_q
);
    import zone3_pkg::*;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sum_q <= 8'h00;
        else if (clear)
            sum_q <= 8'h00;
        else if (add)
            sum_q <= byte_sum(sum_q, data);
    end
endmodule // zone3_sum_acc

// ### verif/fru_store_model.sv
/*
 * Behavioural FRU store seen by the checker: a byte array answering
 * each read strobe after a settable number of idle cycles.
 * Assumes one read outstanding at a time, on the checker's clock.
 */
`timescale 1ns/1ps
module fru_store_model
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fru_rd,
    input wire logic [15:0] fru_addr,
    output logic fru_valid,
    output logic [7:0] fru_data
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_q;
    logic pend_q;
    int wait_q;
    int lat;
    int reads;

    // ========================================
    // read answer
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fru_valid <= 1'b0;
            fru_data <= 8'h00;
            pend_q <= 1'b0;
            wait_q <= 0;
            reads <= 0;
        end
        else
        begin
            fru_valid <= 1'b0;
            if (fru_rd)
            begin
                addr_q <= fru_addr;
                wait_q <= lat;
                pend_q <= 1'b1;
                reads <= reads + 1;
            end
            else if (pend_q && wait_q != 0)
                wait_q <= wait_q - 1;
            else if (pend_q)
            begin
                fru_valid <= 1'b1;
                fru_data <= mem[addr_q];
                pend_q <= 1'b0;
            end
            else
                // stale byte must not look held once released
                fru_data <= ~fru_data;
        end
    end
endmodule // fru_store_model

// ### verif/zone3_compat_record_checker_bench.sv
/*
 * Self-checking bench for the compatibility checker: builds record
 * lists in the store model and judges each walk's verdict.
 * Assumes the default reference record of the checker's ROM.
 */
`timescale 1ns/1ps
module zone3_compat_record_checker_bench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [15:0] list_base = 16'h0000;
    logic fru_rd_q, fru_valid, busy_q, done_q, compatible_q, list_error_q;
    logic [15:0] fru_addr_q;
    logic [7:0] fru_data;
    int fails = 0;
    int checks = 0;
    // reference bytes, fields low byte first
    logic [7:0] ref_b [0:17] = '{8'hc0, 8'h82, 8'h0d, 8'h00, 8'h00,
        8'h02, 8'h00, 8'h00, 8'h30, 8'h01, 8'h03,
        8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

    always #12.5 clock = ~clock;

    zone3_compat_checker DUT (.clock(clock), .rst_n(rst_n),
        .start(start), .list_base(list_base), .fru_rd_q(fru_rd_q),
        .fru_addr_q(fru_addr_q), .fru_valid(fru_valid),
        .fru_data(fru_data), .busy_q(busy_q), .done_q(done_q),
        .compatible_q(compatible_q), .list_error_q(list_error_q));

    fru_store_model store (.clock(clock), .rst_n(rst_n), .fru_rd(fru_rd_q),
        .fru_addr(fru_addr_q), .fru_valid(fru_valid), .fru_data(fru_data));

    // ========================================
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks++;
            if (seen !== exp)
            begin
                fails++;
                $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task finish_test;
        begin
            $display("comparisons %0d, mismatches %0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task put_rec(input logic [15:0] base, input logic [7:0] typ, flags, len,
                 input int off, input logic [7:0] flip, input logic [1:0] bad);
        logic [7:0] b [0:31];
        logic [7:0] s;
        begin
            s = 8'h00;
            for (int i = 5; i < 5 + len; i++)
            begin
                b[i] = (i < 18) ? ref_b[i] : 8'h5a;
                if (i == off)
                    b[i] = b[i] ^ flip;
                s = s + b[i];
            end
            b[0] = typ;
            b[1] = flags;
            b[2] = len;
            b[3] = 8'h00 - s + {7'h00, bad[0]};
            b[4] = 8'h00 - (typ + flags + len + b[3]) + {7'h00, bad[1]};
            for (int i = 0; i < 5 + len; i++)
                store.mem[base + 16'(i)] = b[i];
        end
    endtask

    task run(input logic [15:0] base, input logic c, e, input int n);
        int k;
        int r0;
        begin
            r0 = store.reads;
            @(posedge clock);
            #2;
            start = 1'b1;
            list_base = base;
            @(posedge clock);
            #2;
            start = 1'b0;
            check({31'h0, busy_q}, 32'h1);
            k = 0;
            while (done_q !== 1'b1 && k < 2000)
            begin
                @(posedge clock);
                #2;
                k++;
            end
            check({31'h0, k == 2000}, 32'h0);
            check({31'h0, busy_q}, 32'h0);
            check({31'h0, compatible_q}, {31'h0, c});
            check({31'h0, list_error_q}, {31'h0, e});
            if (n >= 0)
                check(store.reads - r0, n);
            $display("walk from %h finished", base);
        end
    endtask

    // single record list, end bit set by the caller's flags
    task single(input logic [7:0] typ, flags, len, input int off,
                input logic [7:0] flip, input logic [1:0] bad, input logic c, e);
        begin
            put_rec(16'h0400, typ, flags, len, off, flip, bad);
            run(16'h0400, c, e, e ? -1 : 5 + len);
        end
    endtask

    // ========================================
    // scenarios
    task t_single;
        begin
            store.lat = 0;
            single(8'hc0, 8'h82, 8'h0d, 0, 8'h00, 2'b00, 1, 0);
            single(8'hc0, 8'h82, 8'h0d, 5, 8'h44, 2'b00, 1, 0);
            single(8'hc1, 8'h82, 8'h0d, 0, 8'h00, 2'b00, 0, 0);
            single(8'hc0, 8'h83, 8'h0d, 0, 8'h00, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 0, 8'h00, 2'b01, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 8, 8'h01, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 9, 8'h02, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 10, 8'h01, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 11, 8'h80, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 13, 8'h01, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 14, 8'h01, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 17, 8'h80, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0e, 0, 8'h00, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0c, 0, 8'h00, 2'b00, 0, 0);
            single(8'hc0, 8'h82, 8'h0d, 0, 8'h00, 2'b10, 0, 1);
        end
    endtask

    task t_lists;
        begin
            store.lat = 2;
            put_rec(16'h0300, 8'hc0, 8'h02, 8'h0d, 0, 8'h00, 2'b00);
            put_rec(16'h0312, 8'hc0, 8'h82, 8'h0d, 0, 8'h00, 2'b10);
            run(16'h0300, 1, 1, -1);
            put_rec(16'h0200, 8'hc0, 8'h02, 8'h0d, 14, 8'h01, 2'b00);
            put_rec(16'h0212, 8'hc0, 8'h82, 8'h0d, 0, 8'h00, 2'b00);
            run(16'h0200, 1, 0, 36);
        end
    endtask

    initial
    begin
        store.lat = 0;
        repeat (20) @(posedge clock);
        #2;
        check({28'h0, busy_q, done_q, compatible_q, list_error_q}, 32'h0);
        rst_n = 1'b1;
        t_single;
        t_lists;
        finish_test;
    end

    // ========================================
    // watchdog, well past the roughly 1500 cycles the walks need
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        finish_test;
    end
endmodule // zone3_compat_record_checker_bench
